/* rrpc_pkg.sv */
`default_nettype none
// ==========================================================
// constants for the remote register poll check block
package rrpc_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] RRPC_IDX_FIRST = 6'h12; // first line-side copy
    localparam logic [5:0] RRPC_IDX_LAST_POLL = 6'h18; // last pollable copy
    localparam logic [5:0] RRPC_IDX_LAST = 6'h1F; // end of line-side copies
    localparam logic [5:0] RRPC_IDX_CTRL = 6'h19; // remote_check_control
    localparam logic [5:0] RRPC_IDX_FETCH = 6'h1F; // remote_fetched_byte
    localparam logic [5:0] RRPC_IDX_IRQ_STAT = 6'h20;
    localparam logic [5:0] RRPC_IDX_IRQ_CLR = 6'h21;
    localparam logic [5:0] RRPC_IDX_IRQ_EN = 6'h22;
    localparam int RRPC_NUM_SHADOW = 7; // 0x12 .. 0x18
    // control register fields
    localparam int RRPC_BIT_POLL = 7;
    localparam int RRPC_BIT_MATCH = 6;
    localparam int RRPC_OFS_LSB = 0;
    localparam int RRPC_OFS_W = 4;
    localparam int RRPC_DATA_W = 8;
    // interrupt layout
    localparam int RRPC_IRQ_W = 1;
    localparam int RRPC_IRQ_DONE = 0;
    // reset values
    localparam logic [7:0] RRPC_BYTE_RST = 8'h00;
    localparam logic [3:0] RRPC_OFS_RST = 4'h0;
    localparam logic [31:0] RRPC_WORD_ZERO = 32'h0000_0000;
    // timing
    localparam int RRPC_POLL_TIME_US = 600;
    localparam int RRPC_CLK_MHZ = 100;
    localparam int RRPC_POLL_CYCLES = RRPC_POLL_TIME_US * RRPC_CLK_MHZ;
    // poll sequencer states
    typedef enum logic [1:0] {
        RRPC_ST_IDLE = 2'b00,
        RRPC_ST_FETCH = 2'b01,
        RRPC_ST_WAIT = 2'b10
    } rrpc_state_t;
endpackage
`default_nettype wire

/* rrpc_top.sv */
// Chosen here: register access over AHB-Lite.
`default_nettype none
module rrpc_top
    import rrpc_pkg::*;
#(
    parameter int POLL_CYCLES = RRPC_POLL_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // fetch port toward the line-side device
    output logic ls_rd_req_o,
    output logic [3:0] ls_rd_addr_o,
    input wire logic ls_rd_ack_i,
    input wire logic [7:0] ls_rd_data_i,
    // interrupt
    output logic irq_o
);
    localparam int TW = $clog2(POLL_CYCLES + 1);
    localparam logic [TW-1:0] T_LAST = TW'(POLL_CYCLES - 1);
    localparam logic [TW-1:0] T_ZERO = '0;

    // ==========================================================
    // bus address phase capture
    logic [5:0] addr_q, addr_d;
    logic wr_q, wr_d, rd_wait_q, rd_wait_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic accept;
    logic wr_ctrl, wr_shadow, wr_clr, wr_en;
    logic [7:0] wbyte;

    assign accept = hsel_i & htrans_i[1] & hready_i;
    assign wbyte = hwdata_i[7:0];
    assign wr_ctrl = wr_q && (addr_q == RRPC_IDX_CTRL);
    assign wr_shadow = wr_q && (addr_q >= RRPC_IDX_FIRST) && (addr_q <= RRPC_IDX_LAST_POLL);
    assign wr_clr = wr_q && (addr_q == RRPC_IDX_IRQ_CLR);
    assign wr_en = wr_q && (addr_q == RRPC_IDX_IRQ_EN);

    // ==========================================================
    // poll state
    rrpc_state_t st_q, st_d;
    logic poll_q, poll_d, match_q, match_d;
    logic [3:0] ofs_q, ofs_d;
    logic [7:0] fetched_q, fetched_d;
    logic [TW-1:0] tmr_q, tmr_d;
    logic [7:0] shadow_q [RRPC_NUM_SHADOW];
    logic [7:0] shadow_sel;
    logic busy, done;
    logic [RRPC_IRQ_W-1:0] stat_q, stat_d, en_q, en_d;

    assign busy = (st_q != RRPC_ST_IDLE);
    assign done = (st_q == RRPC_ST_WAIT) && (tmr_q == T_LAST);

    // local copy of the selected register, zero outside the pollable range
    always_comb begin
        shadow_sel = RRPC_BYTE_RST;
        if (ofs_q < 4'(RRPC_NUM_SHADOW)) begin
            shadow_sel = shadow_q[3'(ofs_q)];
        end
    end

    // bus next state; reads take one wait state so data leave a flop
    always_comb begin
        addr_d = addr_q;
        wr_d = 1'b0;
        rd_wait_d = 1'b0;
        hrdata_d = hrdata_q;
        if (accept) begin
            addr_d = haddr_i[7:2];
            wr_d = hwrite_i;
            rd_wait_d = ~hwrite_i;
        end
        if (rd_wait_q) begin
            hrdata_d = RRPC_WORD_ZERO; // unmapped and reserved read as zero
            if (addr_q >= RRPC_IDX_FIRST && addr_q <= RRPC_IDX_LAST_POLL) begin
                hrdata_d[7:0] = shadow_q[3'(addr_q - RRPC_IDX_FIRST)];
            end else if (addr_q == RRPC_IDX_CTRL) begin
                hrdata_d[RRPC_BIT_POLL] = poll_q;
                hrdata_d[RRPC_BIT_MATCH] = match_q;
                hrdata_d[RRPC_OFS_LSB +: RRPC_OFS_W] = ofs_q;
            end else if (addr_q == RRPC_IDX_FETCH) begin
                hrdata_d[7:0] = fetched_q;
            end else if (addr_q == RRPC_IDX_IRQ_STAT) begin
                hrdata_d[RRPC_IRQ_W-1:0] = stat_q;
            end else if (addr_q == RRPC_IDX_IRQ_EN) begin
                hrdata_d[RRPC_IRQ_W-1:0] = en_q;
            end
        end
    end

    // bus registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_q <= 6'h00;
            wr_q <= 1'b0;
            rd_wait_q <= 1'b0;
            hrdata_q <= RRPC_WORD_ZERO;
        end else begin
            addr_q <= addr_d;
            wr_q <= wr_d;
            rd_wait_q <= rd_wait_d;
            hrdata_q <= hrdata_d;
        end
    end

    assign hrdata_o = hrdata_q;
    assign hreadyout_o = ~rd_wait_q;
    assign hresp_o = 1'b0;

    // ==========================================================
    // local copies written by software
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < RRPC_NUM_SHADOW; i++) begin
                shadow_q[i] <= RRPC_BYTE_RST;
            end
        end else if (wr_shadow) begin
            shadow_q[3'(addr_q - RRPC_IDX_FIRST)] <= wbyte;
        end
    end

    // ==========================================================
    // poll sequencer next state
    always_comb begin
        st_d = st_q;
        poll_d = poll_q;
        match_d = match_q;
        ofs_d = ofs_q;
        fetched_d = fetched_q;
        tmr_d = tmr_q;
        case (st_q)
            RRPC_ST_IDLE: begin
                tmr_d = T_ZERO;
                if (wr_ctrl) begin
                    ofs_d = wbyte[RRPC_OFS_LSB +: RRPC_OFS_W];
                    if (wbyte[RRPC_BIT_POLL]) begin
                        poll_d = 1'b1;
                        st_d = RRPC_ST_FETCH;
                    end
                end
            end
            RRPC_ST_FETCH: begin
                // writes to request and offset ignored here
                tmr_d = (tmr_q == T_LAST) ? tmr_q : tmr_q + 1'b1;
                if (ls_rd_ack_i) begin
                    fetched_d = ls_rd_data_i;
                    st_d = RRPC_ST_WAIT;
                end
            end
            RRPC_ST_WAIT: begin
                if (tmr_q == T_LAST) begin
                    match_d = (fetched_q == shadow_sel);
                    poll_d = 1'b0;
                    st_d = RRPC_ST_IDLE;
                end else begin
                    tmr_d = tmr_q + 1'b1;
                end
            end
            default: begin
                st_d = RRPC_ST_IDLE;
                poll_d = 1'b0;
            end
        endcase
    end

    // poll sequencer registers; flag and fetched byte have no write path
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= RRPC_ST_IDLE;
            poll_q <= 1'b0;
            match_q <= 1'b0;
            ofs_q <= RRPC_OFS_RST;
            fetched_q <= RRPC_BYTE_RST;
            tmr_q <= T_ZERO;
        end else begin
            st_q <= st_d;
            poll_q <= poll_d;
            match_q <= match_d;
            ofs_q <= ofs_d;
            fetched_q <= fetched_d;
            tmr_q <= tmr_d;
        end
    end

    // fetch request held until the line side answers
    assign ls_rd_req_o = (st_q == RRPC_ST_FETCH);
    assign ls_rd_addr_o = ofs_q;

    // ==========================================================
    // interrupt: sticky status, set wins over clear
    always_comb begin
        stat_d = stat_q;
        en_d = en_q;
        if (wr_clr) begin
            stat_d = stat_q & ~hwdata_i[RRPC_IRQ_W-1:0];
        end
        if (done) begin
            stat_d[RRPC_IRQ_DONE] = 1'b1;
        end
        if (wr_en) begin
            en_d = hwdata_i[RRPC_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_q <= '0;
            en_q <= '0;
        end else begin
            stat_q <= stat_d;
            en_q <= en_d;
        end
    end

    assign irq_o = |(stat_q & en_q);

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_poll_held;
        busy |-> poll_q;
    endproperty
    a_poll_held: assert property (p_poll_held) else $error("request bit low during check");

    property p_poll_clear;
        done |=> !poll_q && !busy;
    endproperty
    a_poll_clear: assert property (p_poll_clear) else $error("request bit not cleared");

    property p_match;
        done |=> match_q == (fetched_q == $past(shadow_sel));
    endproperty
    a_match: assert property (p_match) else $error("equality flag wrong");

    property p_store;
        (st_q == RRPC_ST_FETCH && ls_rd_ack_i) |=> fetched_q == $past(ls_rd_data_i);
    endproperty
    a_store: assert property (p_store) else $error("fetched byte not stored");

    property p_req_addr;
        busy |=> $stable(ofs_q) && (!ls_rd_req_o || ls_rd_addr_o == ofs_q);
    endproperty
    a_req_addr: assert property (p_req_addr) else $error("fetch offset moved");

    property p_start;
        (!busy && wr_ctrl && wbyte[RRPC_BIT_POLL]) |=> ls_rd_req_o && poll_q
            && ofs_q == $past(wbyte[RRPC_OFS_LSB +: RRPC_OFS_W]);
    endproperty
    a_start: assert property (p_start) else $error("request did not start fetch");

    property p_time;
        done |-> tmr_q == T_LAST;
    endproperty
    a_time: assert property (p_time) else $error("check ended early");

    property p_ro;
        (wr_q && addr_q == RRPC_IDX_FETCH && !(ls_rd_req_o && ls_rd_ack_i))
            |=> $stable(fetched_q);
    endproperty
    a_ro: assert property (p_ro) else $error("fetched byte written by bus");

    property p_ack_drop;
        (ls_rd_req_o && ls_rd_ack_i) |=> !ls_rd_req_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("fetch request held after ack");

    property p_irq_clr;
        (wr_clr && hwdata_i[RRPC_IRQ_DONE] && !done) |=> !stat_q[RRPC_IRQ_DONE];
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("done status not cleared");

    property p_irq;
        done |=> stat_q[RRPC_IRQ_DONE] ##0 (irq_o == en_q[RRPC_IRQ_DONE]);
    endproperty
    a_irq: assert property (p_irq) else $error("done status not raised");

    c_match: cover property (done ##1 match_q);
    c_mismatch: cover property (done ##1 !match_q);
    c_ignored: cover property (busy && wr_ctrl);
    c_irq: cover property (irq_o);
endmodule
`default_nettype wire

/* rrpc_ls_model.sv */
`default_nettype none
// ==========================================
// line-side device model: answers fetches after a set delay
module rrpc_ls_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] delay_i,
    output logic ack_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem_q [16];
    logic [7:0] cnt_q;
    // one-cycle ack after delay_i cycles; data toggles while idle
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
            ack_o <= 1'b0;
            data_o <= 8'h00;
        end else begin
            ack_o <= 1'b0;
            data_o <= ~data_o;
            if (req_i && !ack_o) begin
                cnt_q <= (cnt_q == delay_i) ? 8'h00 : cnt_q + 8'h01;
                if (cnt_q == delay_i) begin
                    ack_o <= 1'b1;
                    data_o <= mem_q[addr_i];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* tb_remote_register_poll_check.sv */
`default_nettype none
// ==========================================
// bench for the remote register poll check
module tb_remote_register_poll_check
    import rrpc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 20;
    typedef struct {logic [31:0] e; logic [31:0] m;} rrpc_exp_t;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rv;
    logic hrdy, hresp, req, ack, irq;
    logic rd_ph = 1'b0;
    logic [3:0] la, ofs;
    logic [7:0] ld, b;
    logic [7:0] dly = 8'h00;
    rrpc_exp_t q[$];
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int k, t0;

    rrpc_top #(.POLL_CYCLES(PC)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .ls_rd_req_o(req), .ls_rd_addr_o(la), .ls_rd_ack_i(ack), .ls_rd_data_i(ld),
        .irq_o(irq)
    );
    rrpc_ls_model i_ls (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .addr_i(la),
        .delay_i(dly), .ack_o(ack), .data_o(ld)
    );

    always #5 clk_i = ~clk_i;

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_irq(input logic e);
        cmp("irq_o", {31'h0, e}, {31'h0, irq});
    endtask

    task automatic end_sim();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // bus cycles: hold each phase until hready is seen high
    task automatic ahb_rd(input logic [5:0] ix, input logic [31:0] e, input logic [31:0] m,
                          output logic [31:0] d);
        q.push_back('{e, m});
        haddr <= {ix, 2'b00};
        hwrite <= 1'b0;
        htrans <= 2'h2;
        @(posedge clk_i);
        while (hrdy !== 1'b1) @(posedge clk_i);
        htrans <= 2'h0;
        @(posedge clk_i);
        while (hrdy !== 1'b1) @(posedge clk_i);
        d = hrdata;
    endtask

    task automatic rd(input logic [5:0] ix, input logic [31:0] e);
        ahb_rd(ix, e, 32'hFFFF_FFFF, rv);
    endtask

    task automatic ahb_wr(input logic [5:0] ix, input logic [31:0] d);
        haddr <= {ix, 2'b00};
        hwrite <= 1'b1;
        htrans <= 2'h2;
        @(posedge clk_i);
        while (hrdy !== 1'b1) @(posedge clk_i);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_i);
        while (hrdy !== 1'b1) @(posedge clk_i);
    endtask

    // takes the oldest note whenever a read answer appears
    always @(posedge clk_i) begin
        if (rd_ph === 1'b1 && hrdy === 1'b1 && q.size() > 0) begin
            cmp("hrdata", q[0].e & q[0].m, hrdata & q[0].m);
            cmp("hresp", 32'h0, {31'h0, hresp});
            void'(q.pop_front());
        end
        if (hrdy === 1'b1) rd_ph <= htrans[1] & ~hwrite;
        if (!rst_n_i) rd_ph <= 1'b0;
    end

    // watchdog on the whole run
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(86997));
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        // reset values, unmapped and reserved places
        rd(RRPC_IDX_CTRL, 32'h0);
        rd(RRPC_IDX_FETCH, 32'h0);
        ahb_wr(6'h3F, 32'hFFFF_FFFF);
        rd(6'h3F, 32'h0);
        ahb_wr(6'h1A, 32'h0000_00FF);
        rd(6'h1A, 32'h0);
        chk_irq(1'b0);
        // offsets 0..6, then the last pollable one again, mismatched
        for (k = 0; k < 8; k++) begin
            b = 8'($urandom()) | ((k == 7) ? 8'h01 : 8'h00);
            ofs = (k == 7) ? 4'h6 : 4'(k);
            i_ls.mem_q[ofs] = b;
            dly <= 8'($urandom_range(24, 0));
            ahb_wr(RRPC_IDX_FIRST + 6'(ofs), {24'h0, b ^ 8'(k % 2)});
            ahb_wr(RRPC_IDX_IRQ_EN, {31'h0, k != 0});
            ahb_wr(RRPC_IDX_CTRL, {24'h0, 4'h8, ofs});
            t0 = cyc;
            ahb_wr(RRPC_IDX_CTRL, 32'h0000_008F);
            ahb_wr(RRPC_IDX_FETCH, 32'h0000_00FF);
            rv = 32'hFFFF_FFFF;
            while (rv[7] !== 1'b0) ahb_rd(RRPC_IDX_CTRL, 32'h0, 32'h0, rv);
            cmp("poll_time", 32'h1, 32'(cyc - t0 >= PC - 2 && cyc - t0 <= PC + 40));
            rd(RRPC_IDX_CTRL, {25'h0, k % 2 == 0, 2'b00, ofs});
            rd(RRPC_IDX_FETCH, {24'h0, b});
            rd(RRPC_IDX_FIRST + 6'(ofs), {24'h0, b ^ 8'(k % 2)});
            chk_irq(k != 0);
            rd(RRPC_IDX_IRQ_STAT, 32'h1);
            ahb_wr(RRPC_IDX_IRQ_CLR, 32'h1);
            rd(RRPC_IDX_IRQ_STAT, 32'h0);
            chk_irq(1'b0);
            ahb_wr(RRPC_IDX_CTRL, 32'h0);
        end
        // reset in the middle of a check
        ahb_wr(RRPC_IDX_CTRL, 32'h0000_0082);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(RRPC_IDX_CTRL, 32'h0);
        rd(RRPC_IDX_FETCH, 32'h0);
        rd(RRPC_IDX_FIRST, 32'h0);
        chk_irq(1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
